// ---- verilog/mbd_pkg.sv ----
// shared constants, types and helpers of the drive's serial register slave
package mbd_pkg;
  localparam int CLK_HZ = 10_000_000;

  // rate select codes; code zero is the reset default
  typedef enum logic [2:0] {
    BAUD_115200 = 3'h0,
    BAUD_57600 = 3'h1,
    BAUD_38400 = 3'h2,
    BAUD_19200 = 3'h3,
    BAUD_9600 = 3'h4
  } mbd_baud_e;

  // function codes and exception codes
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE1 = 8'h06;
  localparam logic [7:0] FC_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // register numbers; wire address plus REG_BASE gives the number
  localparam logic [15:0] REG_BASE = 16'h0001;
  localparam logic [15:0] REG_COMMAND = 16'h0001;
  localparam logic [15:0] REG_SPEED = 16'h0002;
  localparam logic [15:0] REG_GAP3 = 16'h0003;
  localparam logic [15:0] REG_RAMP = 16'h0004;
  localparam logic [15:0] REG_STATUS = 16'h0006;
  localparam logic [15:0] REG_OUTFREQ = 16'h0007;
  localparam logic [15:0] REG_OUTCUR = 16'h0008;
  localparam logic [15:0] REG_DIGIN = 16'h000b;
  localparam logic [15:0] REG_AN1 = 16'h0014;
  localparam logic [15:0] REG_AN2 = 16'h0015;
  localparam logic [15:0] REG_SPDREF = 16'h0016;
  localparam logic [15:0] REG_BUSV = 16'h0017;
  localparam logic [15:0] REG_TEMP = 16'h0018;
  localparam logic [15:0] MULTI_LAST = 16'h0004;
  localparam logic [15:0] PARAM_FIRST = 16'h0084;
  localparam logic [15:0] PARAM_LAST = 16'h00bc;

  // command word bits, value limits, reset values
  localparam int CMD_RUN = 0;
  localparam int CMD_DECEL2 = 1;
  localparam int CMD_FAULTRST = 2;
  localparam int CMD_COAST = 3;
  localparam logic [15:0] SPEED_MAX = 16'h1388;
  localparam logic [15:0] RAMP_MAX = 16'hea60;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] MIN_FRAME = 8'h08;
  localparam logic [7:0] HDR_WRITEN = 8'h09;
  localparam logic [7:0] EXC_LEN = 8'h05;

  typedef struct packed {
    logic [7:0] driveState;
    logic [7:0] errorCode;
    logic [15:0] outFreq;
    logic [15:0] outCurrent;
    logic [3:0] digIn;
    logic [15:0] analogOne;
    logic [15:0] analogTwo;
    logic [15:0] speedRef;
    logic [15:0] busVolt;
    logic [15:0] heatsink;
  } mbd_status_s;

  typedef struct packed {
    logic runEnable;
    logic decelSel;
    logic faultReset;
    logic coastStop;
    logic [15:0] speedSetpoint;
    logic [15:0] rampTime;
  } mbd_cmd_s;

  function automatic logic [10:0] baudDiv(input logic [2:0] sel);
    case (sel)
      BAUD_57600: baudDiv = 11'(CLK_HZ / 57600);
      BAUD_38400: baudDiv = 11'(CLK_HZ / 38400);
      BAUD_19200: baudDiv = 11'(CLK_HZ / 19200);
      BAUD_9600: baudDiv = 11'(CLK_HZ / 9600);
      default: baudDiv = 11'(CLK_HZ / 115200);
    endcase
  endfunction

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crcByte = r;
  endfunction
endpackage

// ---- verilog/mbd_uart_rx.sv ----
// serial character receiver, start, eight data lsb first, stop
`timescale 1ns/10ps
`default_nettype none
module mbd_uart_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bit period in clocks
  input wire logic [10:0] divisor,
  // line and received character
  input wire logic rxd,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic rxError
);
  logic busy;
  logic [3:0] bitIdx;
  logic [10:0] cnt;
  wire tick = busy && cnt == 11'h000;
  wire inStop = bitIdx == 4'h9;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      bitIdx <= 4'h0;
      cnt <= 11'h000;
      rxByte <= 8'h00;
      rxValid <= 1'b0;
      rxError <= 1'b0;
    end else begin
      rxValid <= tick && inStop && rxd;
      rxError <= tick && inStop && !rxd;
      if (!busy) begin
        // first sample lands mid start bit
        busy <= !rxd;
        cnt <= divisor >> 1;
        bitIdx <= 4'h0;
      end else if (tick) begin
        cnt <= divisor - 11'h001;
        bitIdx <= bitIdx + 4'h1;
        if (bitIdx == 4'h0) begin
          busy <= !rxd;
        end else if (!inStop) begin
          rxByte <= {rxd, rxByte[7:1]};
        end else begin
          busy <= 1'b0;
        end
      end else begin
        cnt <= cnt - 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/mbd_uart_tx.sv ----
// serial character transmitter, one byte per valid and ready
`timescale 1ns/10ps
`default_nettype none
module mbd_uart_tx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bit period in clocks
  input wire logic [10:0] divisor,
  // byte stream
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  // line
  output logic txd
);
  logic busy;
  logic [3:0] left;
  logic [10:0] cnt;
  logic [8:0] shift;

  assign txReady = !busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      left <= 4'h0;
      cnt <= 11'h000;
      shift <= 9'h1ff;
      txd <= 1'b1;
    end else if (!busy) begin
      if (txValid) begin
        busy <= 1'b1;
        txd <= 1'b0;
        shift <= {1'b1, txData};
        left <= 4'h9;
        cnt <= divisor - 11'h001;
      end
    end else if (cnt != 11'h000) begin
      cnt <= cnt - 11'h001;
    end else if (left == 4'h0) begin
      // stop bit complete
      busy <= 1'b0;
    end else begin
      txd <= shift[0];
      shift <= {1'b1, shift[8:1]};
      left <= left - 4'h1;
      cnt <= divisor - 11'h001;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/mbd_drive_slave.sv ----
// serial register slave of the drive: framing, decode, register file, reply
// Operation
// [R1] five rates, 115200 after reset
// [R2] start, eight data, stop, no parity
// [R3] half duplex; drive line only answering
// [R4] code 03 reads contiguous holding registers
// [R5] code 06 writes one writable register
// [R6] code 16 only for registers 1-4
// [R7] command bit 0: stop or run enable
// [R8] command bit 1: deceleration ramp select
// [R9] command bit 2 requests fault reset
// [R10] command bit 3 requests coast stop
// [R11] register 2: speed setpoint, hertz times ten
// [R12] register 4: ramp time, 0 to 60000
// [R13] register 6 low byte: error code
// [R14] register 6 high byte: drive state
// [R15] register 7: output frequency
// [R16] register 8: output current
// [R17] register 11: four inputs, input 1 lsb
// [R18] registers 20, 21: analog inputs
// [R19] register 22: active speed reference
// [R20] register 23: bus voltage
// [R21] register 24: heatsink temperature
// [R22] parameter n at register 128 plus n
// [R23] bad crc frame silently dropped
// [R24] illegal requests answered with exception
`timescale 1ns/10ps
`default_nettype none
module mbd_drive_slave
  import mbd_pkg::*;
#(
  parameter int BUF_DEPTH = 20,
  parameter int MAX_READ = 16,
  parameter int GAP_BITS = 39,
  parameter int PARAM_COUNT = 57
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // two-wire line
  input wire logic rxd,
  output logic txd,
  output logic txOe,
  // configuration
  input wire logic [7:0] nodeAddr,
  input wire logic [2:0] baudSel,
  // drive side
  input wire mbd_status_s status,
  output mbd_cmd_s command,
  output logic [PARAM_COUNT*16-1:0] paramFile
);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int PW = $clog2(PARAM_COUNT);

  typedef enum logic [4:0] {
    ST_RX = 5'h01,
    ST_CHK = 5'h02,
    ST_WR = 5'h04,
    ST_TX = 5'h08,
    ST_END = 5'h10
  } mbd_state_e;

  mbd_state_e state;
  logic [2:0] baudReg;
  logic [7:0] frameBuf [BUF_DEPTH];
  logic [CW-1:0] rxCnt;
  logic rxBad;
  logic [15:0] rxCrc;
  logic [15:0] gapCnt;
  logic [7:0] excCode;
  logic [7:0] idx;
  logic [7:0] txPtr;
  logic [15:0] txCrc;
  logic txValid;
  logic [15:0] cmdWord;
  logic [15:0] speedSet;
  logic [15:0] rampReg;
  logic [7:0] rxByte;
  logic rxValid;
  logic rxError;
  logic txReady;
  logic [7:0] txByte;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  // [R1] rate divisor from sampled select
  wire [10:0] divisor = baudDiv(baudReg);

  // [R2] character framing
  mbd_uart_rx rxUnit (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .rxd(rxd),
    .rxByte(rxByte),
    .rxValid(rxValid),
    .rxError(rxError)
  );

  mbd_uart_tx txUnit (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .txData(txByte),
    .txValid(txValid),
    .txReady(txReady),
    .txd(txd)
  );

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // own echo is ignored: bytes count only while listening
  wire rxEvent = (state == ST_RX) && (rxValid || rxError);
  wire rxRoom = rxCnt < CW'(BUF_DEPTH);
  wire [15:0] gapLimit = 16'(divisor * GAP_BITS);
  wire gapDone = (state == ST_RX) && rxCnt != '0 && gapCnt >= gapLimit;
  wire [7:0] fc = frameBuf[1];
  wire [15:0] regNum = {frameBuf[2], frameBuf[3]} + REG_BASE;
  wire [15:0] qty = {frameBuf[4], frameBuf[5]};
  wire [7:0] byteCnt = frameBuf[6];
  wire [7:0] rxLen = 8'(rxCnt);
  wire isRead = fc == FC_READ;
  wire isWrN = fc == FC_WRITEN;
  wire [7:0] wantLen = isWrN ? HDR_WRITEN + byteCnt : MIN_FRAME;
  wire [15:0] multiEnd = regNum + qty - 16'h0001;
  wire fcKnown = isRead || isWrN || fc == FC_WRITE1;
  // [R23] residue over data and check word is zero
  wire frameOk = rxCrc == 16'h0000 && !rxBad && frameBuf[0] == nodeAddr && rxLen >= MIN_FRAME;

  // [R24] request checks before anything is touched
  wire [7:0] excInit =
    !fcKnown ? EXC_FUNC :
    rxLen != wantLen ? EXC_VALUE :
    isRead && (qty == 16'h0000 || qty > 16'(MAX_READ)) ? EXC_VALUE :
    isWrN && (qty == 16'h0000 || 16'(byteCnt) != qty << 1) ? EXC_VALUE :
    // [R6] multi write confined to 1..4
    isWrN && multiEnd > MULTI_LAST ? EXC_ADDR :
    EXC_NONE;

  // ----------------------------------------------------------------
  // per register walk
  // ----------------------------------------------------------------
  wire [15:0] curReg = regNum + 16'(idx);
  wire [CW-1:0] valPtr = CW'(7 + 2 * int'(idx));
  wire [15:0] curVal = isWrN ? {frameBuf[valPtr], frameBuf[valPtr + CW'(1)]} : qty;
  wire [15:0] lastIdx = isWrN || isRead ? qty - 16'h0001 : 16'h0000;
  wire idxLast = 16'(idx) == lastIdx;
  wire curParam = curReg >= PARAM_FIRST && curReg <= PARAM_LAST;
  wire curFixedRo = curReg == REG_STATUS || curReg == REG_OUTFREQ || curReg == REG_OUTCUR ||
    curReg == REG_DIGIN || (curReg >= REG_AN1 && curReg <= REG_TEMP);
  wire curWritable = curReg == REG_COMMAND || curReg == REG_SPEED || curReg == REG_RAMP ||
    curParam;
  wire curValOk = !(curReg == REG_SPEED && curVal > SPEED_MAX) &&
    !(curReg == REG_RAMP && curVal > RAMP_MAX);
  // register 3 inside a multi write is skipped, not refused
  wire skipGap = isWrN && curReg == REG_GAP3;
  // [R4] read range must be fully mapped
  wire [7:0] chkCode =
    isRead ? ((curWritable || curFixedRo) ? EXC_NONE : EXC_ADDR) :
    skipGap ? EXC_NONE :
    // [R5] writes only to writable registers
    !curWritable ? EXC_ADDR :
    !curValOk ? EXC_VALUE : EXC_NONE;

  wire wrEn = state == ST_WR && !skipGap;

  // ----------------------------------------------------------------
  // reply assembly
  // ----------------------------------------------------------------
  wire isExc = excCode != EXC_NONE;
  wire [7:0] respLen = isExc ? EXC_LEN : isRead ? EXC_LEN + 8'(qty << 1) : MIN_FRAME;
  wire [7:0] bodyLen = respLen - 8'h02;
  wire [7:0] dataOff = txPtr - 8'h03;
  wire [15:0] rdReg = regNum + 16'(dataOff >> 1);
  wire [15:0] pOff = rdReg - PARAM_FIRST;
  wire [15:0] rdParam = paramFile[{pOff[PW-1:0], 4'h0} +: 16];
  logic [15:0] rdWord;

  always_comb begin
    case (rdReg)
      REG_COMMAND: rdWord = cmdWord;
      REG_SPEED: rdWord = speedSet;
      REG_RAMP: rdWord = rampReg;
      // [R13] [R14] error low, state high
      REG_STATUS: rdWord = {status.driveState, status.errorCode};
      // [R15] output frequency
      REG_OUTFREQ: rdWord = status.outFreq;
      // [R16] output current
      REG_OUTCUR: rdWord = status.outCurrent;
      // [R17] input 1 in bit 0
      REG_DIGIN: rdWord = {12'h000, status.digIn};
      // [R18] analog levels
      REG_AN1: rdWord = status.analogOne;
      REG_AN2: rdWord = status.analogTwo;
      // [R19] active reference
      REG_SPDREF: rdWord = status.speedRef;
      // [R20] bus voltage
      REG_BUSV: rdWord = status.busVolt;
      // [R21] heatsink temperature
      REG_TEMP: rdWord = status.heatsink;
      // [R22] parameter window
      default: rdWord = (rdReg >= PARAM_FIRST && rdReg <= PARAM_LAST) ? rdParam : 16'h0000;
    endcase
  end

  assign txByte =
    txPtr == bodyLen ? txCrc[7:0] :
    txPtr > bodyLen ? txCrc[15:8] :
    txPtr == 8'h00 ? nodeAddr :
    txPtr == 8'h01 ? (isExc ? fc | EXC_FLAG : fc) :
    isExc ? excCode :
    !isRead ? frameBuf[CW'(txPtr)] :
    txPtr == 8'h02 ? 8'(qty << 1) :
    dataOff[0] ? rdWord[7:0] : rdWord[15:8];
  wire txAcc = txValid && txReady;
  wire txLast = txAcc && txPtr == respLen - 8'h01;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RX;
      excCode <= EXC_NONE;
      idx <= 8'h00;
      txPtr <= 8'h00;
      txCrc <= CRC_INIT;
      txValid <= 1'b0;
      txOe <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (gapDone && frameOk) begin
            state <= ST_CHK;
            excCode <= excInit;
            idx <= 8'h00;
          end
        end
        ST_CHK: begin
          if (isExc || chkCode != EXC_NONE || (idxLast && isRead)) begin
            excCode <= isExc ? excCode : chkCode;
            state <= ST_TX;
            txPtr <= 8'h00;
            txCrc <= CRC_INIT;
            txValid <= 1'b1;
            // [R3] driver on only for the reply
            txOe <= 1'b1;
          end else if (idxLast) begin
            state <= ST_WR;
            idx <= 8'h00;
          end else begin
            idx <= idx + 8'h01;
          end
        end
        ST_WR: begin
          idx <= idx + 8'h01;
          if (idxLast) begin
            state <= ST_TX;
            txPtr <= 8'h00;
            txCrc <= CRC_INIT;
            txValid <= 1'b1;
            txOe <= 1'b1;
          end
        end
        ST_TX: begin
          if (txAcc) begin
            txPtr <= txPtr + 8'h01;
            if (txPtr < bodyLen) begin
              txCrc <= crcByte(txCrc, txByte);
            end
          end
          if (txLast) begin
            txValid <= 1'b0;
            state <= ST_END;
          end
        end
        ST_END: begin
          // release only after the stop bit has left
          if (txReady) begin
            txOe <= 1'b0;
            state <= ST_RX;
          end
        end
        default: state <= ST_RX;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudReg <= BAUD_115200;
      rxCnt <= '0;
      rxBad <= 1'b0;
      rxCrc <= CRC_INIT;
      gapCnt <= 16'h0000;
    end else begin
      baudReg <= baudSel;
      if (gapDone || state != ST_RX) begin
        // [R23] bad frames leave no trace
        rxCnt <= '0;
        rxBad <= 1'b0;
        rxCrc <= CRC_INIT;
        gapCnt <= 16'h0000;
      end else if (rxEvent) begin
        gapCnt <= 16'h0000;
        rxCnt <= rxRoom ? rxCnt + CW'(1) : rxCnt;
        rxBad <= rxBad || rxError || !rxRoom;
        rxCrc <= crcByte(rxCrc, rxByte);
      end else if (gapCnt != gapLimit) begin
        gapCnt <= gapCnt + 16'h0001;
      end
    end
  end

  // data storage, no reset needed
  always_ff @(posedge clk) begin
    if (rxEvent && rxRoom) begin
      frameBuf[rxCnt] <= rxByte;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdWord <= WORD_RESET;
      speedSet <= WORD_RESET;
      rampReg <= WORD_RESET;
    end else if (wrEn) begin
      if (curReg == REG_COMMAND) begin
        cmdWord <= curVal;
      end
      // [R11] setpoint stored as written
      if (curReg == REG_SPEED) begin
        speedSet <= curVal;
      end
      // [R12] ramp time, range checked earlier
      if (curReg == REG_RAMP) begin
        rampReg <= curVal;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PARAM_COUNT; gi++) begin : gParam
      // [R22] one word per parameter
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          paramFile[gi*16 +: 16] <= WORD_RESET;
        end else if (wrEn && curReg == PARAM_FIRST + 16'(gi)) begin
          paramFile[gi*16 +: 16] <= curVal;
        end
      end
    end
  endgenerate

  // [R7] [R8] [R9] [R10] command bits to the drive
  assign command.runEnable = cmdWord[CMD_RUN];
  assign command.decelSel = cmdWord[CMD_DECEL2];
  assign command.faultReset = cmdWord[CMD_FAULTRST];
  assign command.coastStop = cmdWord[CMD_COAST];
  assign command.speedSetpoint = speedSet;
  assign command.rampTime = rampReg;
endmodule
`default_nettype wire

// ---- tb/mbd_drive_slave_sva.sv ----
// assertions on the drive slave's ports
`timescale 1ns/10ps
`default_nettype none
module mbd_drive_slave_sva
  import mbd_pkg::*;
#(
  parameter int GAP_BITS = 39,
  parameter int PARAM_COUNT = 57
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line
  input wire logic rxd,
  input wire logic txd,
  input wire logic txOe,
  // configuration
  input wire logic [7:0] nodeAddr,
  input wire logic [2:0] baudSel,
  // drive side
  input wire mbd_status_s status,
  input wire mbd_cmd_s command,
  input wire logic [PARAM_COUNT*16-1:0] paramFile
);
  // ----
  // quiet line
  // ----
  // the fastest rate gives the shortest legal gap, so it is the safe bound
  localparam int GAP_CLKS = GAP_BITS * 86;
  logic [15:0] quietCnt;
  logic [15:0] next_quietCnt;
  assign next_quietCnt = (!rxd) ? 16'h0000 : quietCnt + {15'h0000, quietCnt != 16'hffff};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quietCnt <= 16'h0000;
    end else begin
      quietCnt <= next_quietCnt;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  idle_high_a: assert property (!txOe |-> txd)
    else $error("line low while released");
  // the driver comes on one clock ahead of the start bit
  start_low_a: assert property ($rose(txOe) |=> !txd)
    else $error("reply does not open with a start bit");
  start_width_a: assert property ($rose(txOe) && baudSel == 3'h0 |=> !txd [*8])
    else $error("start bit too short");
  stop_high_a: assert property ($fell(txOe) |-> $past(txd))
    else $error("driver released before stop bit");
  gap_first_a: assert property ($rose(txOe) |-> quietCnt >= 16'(GAP_CLKS))
    else $error("reply before the line went quiet");
  cmd_ack_a: assert property (!$stable(command) |-> ##[0:8] $rose(txOe))
    else $error("command changed without a reply");
  param_ack_a: assert property (!$stable(paramFile) |-> ##[0:8] $rose(txOe))
    else $error("parameter changed without a reply");
  reply_freeze_a: assert property (txOe && $past(txOe) |->
    $stable(command) && $stable(paramFile)) else $error("state changed while replying");
  reset_clear_a: assert property ($rose(rst_n) |->
    command == '0 && paramFile == '0 && !txOe) else $error("state not cleared by reset");
endmodule
bind mbd_drive_slave mbd_drive_slave_sva #(.GAP_BITS(GAP_BITS), .PARAM_COUNT(PARAM_COUNT)) u_chk (
  .clk(clk), .rst_n(rst_n), .rxd(rxd), .txd(txd), .txOe(txOe), .nodeAddr(nodeAddr),
  .baudSel(baudSel), .status(status), .command(command), .paramFile(paramFile)
);
`default_nettype wire

// ---- tb/mbd_master_model.sv ----
// network master model: sends requests, collects replies
`timescale 1ns/10ps
`default_nettype none
module mbd_master_model #(
  // bit period at the default rate
  parameter int DIV = 86
) (
  // clock
  input wire logic clk,
  // shared pair
  input wire logic busLine,
  input wire logic slaveOe,
  output logic drvLine
);
  // ----
  // framing
  // ----
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  // bias holds the released pair high
  initial drvLine = 1'b1;
  function automatic logic [15:0] crcAdd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction
  task automatic putByte(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drvLine = sh[i];
      repeat (DIV) @(negedge clk);
    end
  endtask
  task automatic sendFrame(input logic bad);
    logic [15:0] c;
    c = 16'hffff;
    foreach (txq[i]) c = crcAdd(c, txq[i]);
    // a spoiled check word must be dropped without a word back
    if (bad) c = c ^ 16'h0001;
    @(negedge clk);
    foreach (txq[i]) putByte(txq[i]);
    putByte(c[7:0]);
    putByte(c[15:8]);
  endtask
  // listen only while the slave drives
  task automatic getReply(output int got);
    logic [7:0] b;
    int t;
    rxq.delete();
    t = 0;
    while (!slaveOe && t < 2000) begin
      @(negedge clk);
      t++;
    end
    while (slaveOe && t < 60000) begin
      if (!busLine) begin
        repeat (DIV / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(negedge clk);
          b[i] = busLine;
        end
        repeat (DIV) @(negedge clk);
        rxq.push_back(b);
        t += 10 * DIV;
      end else begin
        @(negedge clk);
        t++;
      end
    end
    got = rxq.size();
  endtask
endmodule
`default_nettype wire

// ---- tb/mbd_drive_slave_bench.sv ----
// self-checking bench for the drive's serial register slave
`timescale 1ns/10ps
`default_nettype none
module mbd_drive_slave_bench;
  import mbd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic masterLine;
  logic txd;
  logic txOe;
  wire busLine;
  mbd_status_s status;
  mbd_cmd_s command;
  logic [57*16-1:0] paramFile;
  logic [7:0] expQ[$];
  int miscompares = 0;
  int nTests = 0;
  always #50 clk = ~clk;
  // the pair carries whichever side has its driver on
  assign busLine = txOe ? txd : masterLine;
  mbd_drive_slave #(.GAP_BITS(12)) i_dut (
    .clk(clk), .rst_n(rst_n), .rxd(busLine), .txd(txd), .txOe(txOe), .nodeAddr(8'h05),
    .baudSel(3'h0), .status(status), .command(command), .paramFile(paramFile)
  );
  mbd_master_model #(.DIV(86)) i_master (
    .clk(clk), .busLine(busLine), .slaveOe(txOe), .drvLine(masterLine)
  );
  // ----
  // checking
  // ----
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic xact(input string nm, input logic bad);
    int got;
    logic [15:0] c;
    c = 16'hffff;
    foreach (expQ[i]) c = i_master.crcAdd(c, expQ[i]);
    if (expQ.size() > 0) begin
      expQ.push_back(c[7:0]);
      expQ.push_back(c[15:8]);
    end
    i_master.sendFrame(bad);
    i_master.getReply(got);
    check({nm, " length"}, 16'(got), 16'(expQ.size()));
    check({nm, " released"}, 16'(txOe), 16'h0000);
    foreach (expQ[i]) begin
      if (i < got) check(nm, {8'h00, i_master.rxq[i]}, {8'h00, expQ[i]});
    end
    if (got == 0 && expQ.size() > 0) closeOut();
  endtask
  // ----
  // scenarios
  // ----
  task automatic readStatus();
    i_master.txq = '{8'h05, 8'h03, 8'h00, 8'h05, 8'h00, 8'h03};
    expQ = '{8'h05, 8'h03, 8'h06, 8'h01, 8'h2a, 8'h01, 8'hf4, 8'h00, 8'h64};
    xact("status read", 1'b0);
    i_master.txq = '{8'h05, 8'h03, 8'h00, 8'h13, 8'h00, 8'h05};
    expQ = '{8'h05, 8'h03, 8'h0a, 8'h03, 8'he8, 8'h01, 8'h23, 8'h00, 8'h32, 8'h01, 8'h50,
      8'h00, 8'h28};
    xact("readout read", 1'b0);
    $display("test status read done");
  endtask
  // multi write inside registers 1 to 4
  task automatic multiWrite();
    i_master.txq = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'h00, 8'h0b,
      8'h13, 8'h88, 8'h00, 8'h00, 8'hea, 8'h60};
    expQ = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h04};
    xact("multi write", 1'b0);
    check("run", 16'(command.runEnable), 16'h0001);
    check("decel select", 16'(command.decelSel), 16'h0001);
    check("fault reset", 16'(command.faultReset), 16'h0000);
    check("coast", 16'(command.coastStop), 16'h0001);
    check("speed", command.speedSetpoint, 16'h1388);
    check("ramp", command.rampTime, 16'hea60);
    $display("test multi write done");
  endtask
  task automatic badFrames();
    i_master.txq = '{8'h05, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
    expQ.delete();
    xact("bad check word", 1'b1);
    check("run kept", 16'(command.runEnable), 16'h0001);
    i_master.txq = '{8'h05, 8'h06, 8'h00, 8'h05, 8'h00, 8'h00};
    expQ = '{8'h05, 8'h86, 8'h02};
    xact("read-only write", 1'b0);
    check("speed kept", command.speedSetpoint, 16'h1388);
    $display("test refused frames done");
  endtask
  task automatic paramWrite();
    i_master.txq = '{8'h05, 8'h06, 8'h00, 8'h8e, 8'h12, 8'h34};
    expQ = '{8'h05, 8'h06, 8'h00, 8'h8e, 8'h12, 8'h34};
    xact("parameter write", 1'b0);
    check("parameter 15", paramFile[11*16 +: 16], 16'h1234);
    check("parameter 14", paramFile[10*16 +: 16], 16'h0000);
    $display("test parameter write done");
  endtask
  initial begin
    status = '{driveState: 8'h01, errorCode: 8'h2a, outFreq: 16'h01f4, outCurrent: 16'h0064,
      digIn: 4'h9, analogOne: 16'h03e8, analogTwo: 16'h0123, speedRef: 16'h0032,
      busVolt: 16'h0150, heatsink: 16'h0028};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    readStatus();
    multiWrite();
    badFrames();
    paramWrite();
    closeOut();
  end
endmodule
`default_nettype wire
